// [core/ctu_core.sv]
// charge time unit control: registers, edge selection, flags, current source, delay pulse
// assumes sources synchronous to clk, register port with read data one cycle later
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "ctu_params.svh"
module ctu_core (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire ctu_pkg::ctu_addr_t reg_addr,
    input wire ctu_pkg::ctu_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output ctu_pkg::ctu_word_t reg_rdata,
    // device state
    input wire logic cpu_idle,
    input wire logic large_pkg,
    // edge sources
    input wire logic timer_one_evt,
    input wire logic output_compare_one,
    input wire ctu_pkg::ctu_pins_t external_edge_pin,
    input wire ctu_pkg::ctu_trio_t input_capture,
    input wire ctu_pkg::ctu_trio_t comparator_out,
    // analog control
    output logic current_source_on,
    output logic current_source_ground,
    output logic [1:0] current_range,
    output logic [5:0] current_trim,
    output logic delay_generation_enable,
    output logic trigger_out,
    output logic pulse_output_pin
);
    import ctu_pkg::*;

    ctu_word_t ctrl1_ff;
    ctu_word_t ctrl2_ff;
    ctu_word_t curr_ff;
    ctu_state_t state_ff;
    ctu_state_t nxt_state;
    logic run;
    logic gate;
    logic src1;
    logic src2;
    logic hit1;
    logic hit2;
    logic take2;
    logic wr1;
    logic wr2;
    logic wrc;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // external pin number (1-based) to usable level, four pins need the large package
    function automatic logic pin_level(input ctu_pins_t pins, input int unsigned num,
                                       input logic big);
        logic ok;
        ok = big | ((num != 3) && (num != 7) && (num != 10) && (num != 11));
        pin_level = ok & pins[num - 1];
    endfunction

    // write strobe aimed at one register index
    function automatic logic wr_hit(input logic strobe, input ctu_addr_t addr,
                                    input ctu_addr_t idx);
        wr_hit = strobe && (addr == idx);
    endfunction

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // one write select per register
    assign wr1 = wr_hit(reg_wr, reg_addr, `CTU_IDX_CTRL1);
    assign wr2 = wr_hit(reg_wr, reg_addr, `CTU_IDX_CTRL2);
    assign wrc = wr_hit(reg_wr, reg_addr, `CTU_IDX_CURR);

    // control register one, reserved bits held at zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1_ff <= `CTU_RST_WORD;
        end else if (wr1) begin
            ctrl1_ff <= reg_wdata & `CTU_C1_MASK;
        end
    end

    // current control register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            curr_ff <= `CTU_RST_WORD;
        end else if (wrc) begin
            curr_ff <= reg_wdata & `CTU_CI_MASK;
        end
    end

    // control register two; hardware set of a flag wins over a software clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl2_ff <= `CTU_RST_WORD;
        end else begin
            if (wr2) begin
                ctrl2_ff <= reg_wdata & `CTU_C2_MASK;
            end
            if (hit1) begin
                ctrl2_ff[`CTU_C2_E1_FLAG] <= 1'b1;
            end
            if (take2) begin
                ctrl2_ff[`CTU_C2_E2_FLAG] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `CTU_RST_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                `CTU_IDX_CTRL1: reg_rdata <= ctrl1_ff;
                `CTU_IDX_CTRL2: reg_rdata <= ctrl2_ff;
                `CTU_IDX_CURR: reg_rdata <= curr_ff;
                default: reg_rdata <= `CTU_RST_WORD;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // run control and edge gating
    // ----------------------------------------------------------------
    // unit runs when enabled and not stopped by idle
    assign run = ctrl1_ff[`CTU_C1_EN]
        & ~(ctrl1_ff[`CTU_C1_SIDL] & cpu_idle);

    // edges leave the detectors only through the gate
    assign gate = run & ctrl1_ff[`CTU_C1_EDGE_GATE];

    // ----------------------------------------------------------------
    // source selection
    // ----------------------------------------------------------------
    // edge one multiplexer
    always_comb begin
        case (ctrl2_ff[`CTU_C2_E1_SEL_HI:`CTU_C2_E1_SEL_LO])
            4'h0: src1 = timer_one_evt;
            4'h1: src1 = output_compare_one;
            4'h2: src1 = pin_level(external_edge_pin, 2, large_pkg);
            4'h3: src1 = pin_level(external_edge_pin, 1, large_pkg);
            4'h4: src1 = pin_level(external_edge_pin, 3, large_pkg);
            4'h5: src1 = pin_level(external_edge_pin, 4, large_pkg);
            4'h6: src1 = pin_level(external_edge_pin, 5, large_pkg);
            4'h7: src1 = pin_level(external_edge_pin, 6, large_pkg);
            4'h8: src1 = pin_level(external_edge_pin, 7, large_pkg);
            4'h9: src1 = pin_level(external_edge_pin, 8, large_pkg);
            4'hA: src1 = input_capture[0];
            4'hB: src1 = input_capture[1];
            4'hC: src1 = input_capture[2];
            4'hD: src1 = comparator_out[0];
            4'hE: src1 = comparator_out[1];
            4'hF: src1 = comparator_out[2];
            default: src1 = 1'b0;
        endcase
    end

    // edge two multiplexer, reserved code gives no source
    always_comb begin
        case (ctrl2_ff[`CTU_C2_E2_SEL_HI:`CTU_C2_E2_SEL_LO])
            4'h0: src2 = timer_one_evt;
            4'h1: src2 = output_compare_one;
            4'h2: src2 = pin_level(external_edge_pin, 2, large_pkg);
            4'h3: src2 = pin_level(external_edge_pin, 1, large_pkg);
            4'h4: src2 = pin_level(external_edge_pin, 9, large_pkg);
            4'h5: src2 = pin_level(external_edge_pin, 10, large_pkg);
            4'h6: src2 = pin_level(external_edge_pin, 11, large_pkg);
            4'h7: src2 = pin_level(external_edge_pin, 12, large_pkg);
            4'h8: src2 = pin_level(external_edge_pin, 13, large_pkg);
            4'h9: src2 = input_capture[0];
            4'hA: src2 = input_capture[1];
            4'hB: src2 = input_capture[2];
            `CTU_SEL_E2_RSVD: src2 = 1'b0;
            4'hD: src2 = comparator_out[0];
            4'hE: src2 = comparator_out[1];
            4'hF: src2 = comparator_out[2];
            default: src2 = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // edge detectors
    // ----------------------------------------------------------------
    // edge one detector
    ctu_edge_det u_edge1 (
        .clk(clk),
        .arst_n(arst_n),
        .edge_mode(ctrl2_ff[`CTU_C2_E1_MOD]),
        .rise_pol(ctrl2_ff[`CTU_C2_E1_POL]),
        .gate(gate),
        .src(src1),
        .hit(hit1)
    );

    // edge two detector
    ctu_edge_det u_edge2 (
        .clk(clk),
        .arst_n(arst_n),
        .edge_mode(ctrl2_ff[`CTU_C2_E2_MOD]),
        .rise_pol(ctrl2_ff[`CTU_C2_E2_POL]),
        .gate(gate),
        .src(src2),
        .hit(hit2)
    );

    // edge two counts only after edge one when ordering is on
    assign take2 = hit2 & (~ctrl1_ff[`CTU_C1_ORDER] | ctrl2_ff[`CTU_C2_E1_FLAG]);

    // ----------------------------------------------------------------
    // current source control
    // ----------------------------------------------------------------
    // on between edge one and edge two flags, grounding overrides
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            current_source_on <= 1'b0;
        end else begin
            current_source_on <= run & ctrl2_ff[`CTU_C2_E1_FLAG]
                & ~ctrl2_ff[`CTU_C2_E2_FLAG] & ~ctrl1_ff[`CTU_C1_GND];
        end
    end

    // ----------------------------------------------------------------
    // analog settings
    // ----------------------------------------------------------------
    // grounding switch follows its control bit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            current_source_ground <= 1'b0;
        end else begin
            current_source_ground <= ctrl1_ff[`CTU_C1_GND];
        end
    end

    // range select copy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            current_range <= 2'h0;
        end else begin
            current_range <= curr_ff[`CTU_CI_RNG_HI:`CTU_CI_RNG_LO];
        end
    end

    // signed trim copy, two's complement passed unchanged
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            current_trim <= 6'h00;
        end else begin
            current_trim <= curr_ff[`CTU_CI_TRIM_HI:`CTU_CI_TRIM_LO];
        end
    end

    // ----------------------------------------------------------------
    // delay generation sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CTU_ST_IDLE: begin
                if (run && ctrl1_ff[`CTU_C1_DELAY_GENERATION_ENABLE] && hit1) begin
                    nxt_state = CTU_ST_CHARGE;
                end
            end
            CTU_ST_CHARGE: begin
                if (!run || !ctrl1_ff[`CTU_C1_DELAY_GENERATION_ENABLE]) begin
                    nxt_state = CTU_ST_IDLE;
                end else if (comparator_out[1]) begin
                    nxt_state = CTU_ST_DONE;
                end
            end
            CTU_ST_DONE: begin
                nxt_state = CTU_ST_IDLE;
            end
            default: nxt_state = CTU_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= CTU_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // delay pulse output
    // ----------------------------------------------------------------
    // one-cycle pulse on the trip of the charge comparator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_output_pin <= 1'b0;
        end else begin
            pulse_output_pin <= (nxt_state == CTU_ST_DONE);
        end
    end

    // ----------------------------------------------------------------
    // trigger and mode outputs
    // ----------------------------------------------------------------
    // trigger pulse on every accepted edge while enabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trigger_out <= 1'b0;
        end else begin
            trigger_out <= run & ctrl1_ff[`CTU_C1_TRIG] & (hit1 | take2);
        end
    end

    // delay mode indication for the comparator path
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            delay_generation_enable <= 1'b0;
        end else begin
            delay_generation_enable <= run & ctrl1_ff[`CTU_C1_DELAY_GENERATION_ENABLE];
        end
    end
endmodule

// [core/ctu_edge_det.sv]
// one edge channel: polarity, edge or level sensitivity, event pulse
// assumes the selected source is synchronous to clk
`timescale 1ns/1ps
module ctu_edge_det (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // configuration
    input wire logic edge_mode,
    input wire logic rise_pol,
    input wire logic gate,
    // source and event
    input wire logic src,
    output logic hit
);
    import ctu_pkg::*;

    logic prev_ff;
    logic active;

    // ----------------------------------------------------------------
    // history of the active level
    // ----------------------------------------------------------------
    // polarity 1 means high / rising is active
    assign active = rise_pol ? src : ~src;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= active;
        end
    end

    // edge mode needs a transition, level mode just the level
    assign hit = gate & (edge_mode ? (active & ~prev_ff) : active);
endmodule

// [core/ctu_params.svh]
// constants for the charge time unit: register indices, field positions, reset values
// assumes a 16-bit register port with word indices
`ifndef CTU_PARAMS_SVH
`define CTU_PARAMS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define CTU_IDX_CTRL1 2'h0
`define CTU_IDX_CTRL2 2'h1
`define CTU_IDX_CURR 2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTU_RST_WORD 16'h0000

// ----------------------------------------------------------------
// control register one fields
// ----------------------------------------------------------------
`define CTU_C1_EN 15
`define CTU_C1_SIDL 13
`define CTU_C1_DELAY_GENERATION_ENABLE 12
`define CTU_C1_EDGE_GATE 11
`define CTU_C1_ORDER 10
`define CTU_C1_GND 9
`define CTU_C1_TRIG 8
`define CTU_C1_MASK 16'hBF00

// ----------------------------------------------------------------
// control register two fields
// ----------------------------------------------------------------
`define CTU_C2_E1_MOD 15
`define CTU_C2_E1_POL 14
`define CTU_C2_E1_SEL_HI 13
`define CTU_C2_E1_SEL_LO 10
`define CTU_C2_E2_FLAG 9
`define CTU_C2_E1_FLAG 8
`define CTU_C2_E2_MOD 7
`define CTU_C2_E2_POL 6
`define CTU_C2_E2_SEL_HI 5
`define CTU_C2_E2_SEL_LO 2
`define CTU_C2_MASK 16'hFFFC

// ----------------------------------------------------------------
// current register fields
// ----------------------------------------------------------------
`define CTU_CI_TRIM_HI 15
`define CTU_CI_TRIM_LO 10
`define CTU_CI_RNG_HI 9
`define CTU_CI_RNG_LO 8
`define CTU_CI_MASK 16'hFF00

// ----------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------
`define CTU_SEL_E2_RSVD 4'hC
`define CTU_PIN_COUNT 13

`endif

// [core/ctu_pkg.sv]
// types shared by the charge time unit files
// assumes ctu_params.svh is on the include path
package ctu_pkg;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [15:0] ctu_word_t;
    typedef logic [1:0] ctu_addr_t;
    typedef logic [3:0] ctu_sel_t;
    typedef logic [12:0] ctu_pins_t;
    typedef logic [2:0] ctu_trio_t;
    typedef enum logic [2:0] {
        CTU_ST_IDLE = 3'h1,
        CTU_ST_CHARGE = 3'h2,
        CTU_ST_DONE = 3'h4
    } ctu_state_t;
endpackage

// [tb/ctu_core_monitor.sv]
// port assertions for the charge time unit core
// assumes registered outputs and read data one cycle after the strobe
`timescale 1ns/1ps
module ctu_core_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire ctu_pkg::ctu_addr_t reg_addr,
    input wire ctu_pkg::ctu_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire ctu_pkg::ctu_word_t reg_rdata,
    // sources and analog control
    input wire ctu_pkg::ctu_trio_t comparator_out,
    input wire logic current_source_on,
    input wire logic current_source_ground,
    input wire logic [1:0] current_range,
    input wire logic [5:0] current_trim,
    input wire logic delay_generation_enable,
    input wire logic pulse_output_pin
);
    import ctu_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // register port answers
    unmapped_read_zero_a: assert property (
        reg_rd && reg_addr == 2'h3 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    read_data_holds_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    // analog copies follow register writes
    ground_copy_a: assert property (
        reg_wr && reg_addr == 2'h0
        |-> ##2 current_source_ground == $past(reg_wdata[9], 2))
        else $error("ground output not ctrl1 bit 9");
    range_trim_copy_a: assert property (
        reg_wr && reg_addr == 2'h2
        |-> ##2 {current_trim, current_range} == $past(reg_wdata[15:8], 2))
        else $error("trim or range output wrong");
    ground_blocks_source_a: assert property (
        current_source_ground && $past(current_source_ground) |-> !current_source_on)
        else $error("current source on while grounded");
    // delay pulse
    pulse_one_cycle_a: assert property (pulse_output_pin |=> !pulse_output_pin)
        else $error("delay pulse longer than one cycle");
    pulse_after_trip_a: assert property (
        pulse_output_pin |-> $past(comparator_out[1]) && $past(delay_generation_enable))
        else $error("delay pulse without trip in delay mode");
    // disable stops the unit
    disable_stops_a: assert property (
        reg_wr && reg_addr == 2'h0 && !reg_wdata[15]
        |-> ##3 !delay_generation_enable && !current_source_on)
        else $error("unit still active after disable");
endmodule

bind ctu_core ctu_core_monitor u_ctu_core_monitor (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .comparator_out(comparator_out),
    .current_source_on(current_source_on), .current_source_ground(current_source_ground),
    .current_range(current_range), .current_trim(current_trim),
    .delay_generation_enable(delay_generation_enable), .pulse_output_pin(pulse_output_pin));

// [tb/ctu_core_test.sv]
// register-level tests of the charge time unit core
// assumes ctu_src_model supplies the edge sources
`timescale 1ns/1ps
module ctu_core_test;
    import ctu_pkg::*;
    logic clk, arst_n, reg_wr, reg_rd, cpu_idle, large_pkg, exp;
    ctu_addr_t reg_addr;
    ctu_word_t reg_wdata, reg_rdata, v;
    logic timer_one_evt, output_compare_one, current_source_on, current_source_ground;
    logic delay_generation_enable, trigger_out, pulse_output_pin;
    ctu_pins_t external_edge_pin;
    ctu_trio_t input_capture, comparator_out;
    logic [1:0] current_range;
    logic [5:0] current_trim;
    logic [20:0] drv;
    int err_total, total_checks, cycles, trig_cnt, pulse_cnt, idx, t;
    ctu_word_t mask [4] = '{16'hBF00, 16'hFFFC, 16'hFF00, 16'h0000};
    ctu_word_t tv [2] = '{16'h7D00, 16'h8400};

    ctu_core u_ctu_core (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_idle(cpu_idle), .large_pkg(large_pkg), .timer_one_evt(timer_one_evt),
        .output_compare_one(output_compare_one), .external_edge_pin(external_edge_pin),
        .input_capture(input_capture), .comparator_out(comparator_out),
        .current_source_on(current_source_on), .current_source_ground(current_source_ground),
        .current_range(current_range), .current_trim(current_trim),
        .delay_generation_enable(delay_generation_enable), .trigger_out(trigger_out),
        .pulse_output_pin(pulse_output_pin));
    ctu_src_model u_ctu_src_model (.clk(clk), .arst_n(arst_n), .drv(drv),
        .current_source_on(current_source_on), .timer_one_evt(timer_one_evt),
        .output_compare_one(output_compare_one), .external_edge_pin(external_edge_pin),
        .input_capture(input_capture), .comparator_out(comparator_out));

    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // pulse counters and hang guard
    always @(posedge clk) begin
        cycles++;
        trig_cnt += (trigger_out === 1'b1);
        pulse_cnt += (pulse_output_pin === 1'b1);
        if (cycles == 8000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input ctu_word_t s, input ctu_word_t e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input ctu_addr_t a, input ctu_word_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input ctu_addr_t a, output ctu_word_t d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rdc(input ctu_addr_t a, input ctu_word_t e);
        ctu_word_t d;
        rd(a, d);
        chk(d, e);
    endtask
    // set one source level, then let the flags settle
    task automatic tick(input int i, input logic l);
        @(posedge clk);
        drv[i] <= l;
        repeat (3) @(posedge clk);
    endtask
    // drive index of each select code, -1 for the reserved code
    function automatic int src_idx(input int ch, input int c);
        if (c < 2) return c;
        if (c < 4) return 5 - c;
        if (ch == 0) return (c < 10) ? c : c + 5;
        if (c == 12) return -1;
        return (c < 12) ? c + 6 : c + 5;
    endfunction

    // main sequence
    initial begin
        {arst_n, reg_wr, reg_rd, cpu_idle, large_pkg} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        drv = '0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 4; a++) rdc(2'(a), 16'h0000);
        for (int a = 0; a < 4; a++) begin
            wr(2'(a), 16'hFFFF);
            rdc(2'(a), mask[a]);
        end
        chk(current_source_ground, 1'b1);
        for (int i = 0; i < 2; i++) begin
            wr(2'h2, tv[i]);
            repeat (2) @(posedge clk);
            chk({current_trim, current_range}, tv[i][15:8]);
        end
        $display("registers done");
        wr(2'h0, 16'h8800);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            large_pkg <= p[0];
            for (int ch = 0; ch < 2; ch++) begin
                for (int c = 0; c < 16; c++) begin
                    idx = src_idx(ch, c);
                    exp = (idx >= 0);
                    if (p == 0 && (ch ? (c == 5 || c == 6) : (c == 4 || c == 8))) exp = 1'b0;
                    wr(2'h1, ch ? 16'hC0C0 | 16'(c << 2) : 16'hC0F0 | 16'(c << 10));
                    if (idx >= 0) tick(idx, 1'b1);
                    else repeat (4) @(posedge clk);
                    rd(2'h1, v);
                    chk(v[8 + ch], exp);
                    @(posedge clk);
                    drv <= '0;
                    repeat (2) @(posedge clk);
                end
            end
        end
        $display("source select done");
        wr(2'h0, 16'h8000);
        wr(2'h1, 16'hC0C4);
        tick(0, 1'b1);
        rdc(2'h1, 16'hC0C4);
        tick(0, 1'b0);
        wr(2'h0, 16'h8D00);
        tick(1, 1'b1);
        rdc(2'h1, 16'hC0C4);
        tick(1, 1'b0);
        t = trig_cnt;
        tick(0, 1'b1);
        chk(current_source_on, 1'b1);
        chk(trig_cnt > t, 1'b1);
        tick(1, 1'b1);
        rdc(2'h1, 16'hC3C4);
        chk(current_source_on, 1'b0);
        tick(0, 1'b0);
        tick(1, 1'b0);
        wr(2'h1, 16'hC1C4);
        repeat (2) @(posedge clk);
        chk(current_source_on, 1'b1);
        wr(2'h0, 16'h8F00);
        repeat (2) @(posedge clk);
        chk(current_source_on, 1'b0);
        wr(2'h0, 16'h8800);
        wr(2'h1, 16'hC0C4);
        t = trig_cnt;
        tick(0, 1'b1);
        chk(trig_cnt == t, 1'b1);
        tick(0, 1'b0);
        $display("edge control done");
        @(posedge clk);
        cpu_idle <= 1'b1;
        wr(2'h0, 16'hA800);
        wr(2'h1, 16'hC0C4);
        tick(0, 1'b1);
        rdc(2'h1, 16'hC0C4);
        tick(0, 1'b0);
        wr(2'h0, 16'h8800);
        tick(0, 1'b1);
        rdc(2'h1, 16'hC1C4);
        wr(2'h1, 16'h8080);
        rdc(2'h1, 16'h8080);
        tick(0, 1'b0);
        rdc(2'h1, 16'h8380);
        @(posedge clk);
        cpu_idle <= 1'b0;
        wr(2'h1, 16'h40F0);
        rdc(2'h1, 16'h40F0);
        tick(0, 1'b1);
        wr(2'h1, 16'h40F0);
        rdc(2'h1, 16'h41F0);
        tick(0, 1'b0);
        $display("idle and sensitivity done");
        wr(2'h1, 16'hC0F0);
        wr(2'h0, 16'h9800);
        repeat (2) @(posedge clk);
        chk(delay_generation_enable, 1'b1);
        t = pulse_cnt;
        tick(0, 1'b1);
        for (int i = 0; i < 100 && pulse_cnt == t; i++) @(posedge clk);
        chk(pulse_cnt == t + 1, 1'b1);
        tick(0, 1'b0);
        wr(2'h0, 16'h0000);
        repeat (3) @(posedge clk);
        chk({delay_generation_enable, current_source_on}, 2'b00);
        $display("delay mode done");
        complete_run();
    end
endmodule

// [tb/ctu_src_model.sv]
// edge sources and delay capacitor seen by the charge time unit
// assumes bench levels on drv: timer, compare, 13 pins, 3 captures, 3 comparators
`timescale 1ns/1ps
module ctu_src_model #(parameter int TRIP = 20) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // bench levels and current source state
    input wire logic [20:0] drv,
    input wire logic current_source_on,
    // source levels to the core
    output logic timer_one_evt,
    output logic output_compare_one,
    output ctu_pkg::ctu_pins_t external_edge_pin,
    output ctu_pkg::ctu_trio_t input_capture,
    output ctu_pkg::ctu_trio_t comparator_out
);
    import ctu_pkg::*;
    int charge_ff;
    // capacitor charges while the source is on, drains when off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            charge_ff <= 0;
        end else if (current_source_on) begin
            charge_ff <= (charge_ff < TRIP) ? charge_ff + 1 : charge_ff;
        end else begin
            charge_ff <= 0;
        end
    end
    // levels pass through; comparator two also trips on charge
    assign timer_one_evt = drv[0];
    assign output_compare_one = drv[1];
    assign external_edge_pin = drv[14:2];
    assign input_capture = drv[17:15];
    assign comparator_out = {drv[20], drv[19] | (charge_ff >= TRIP), drv[18]};
endmodule
